// ===== dv/dmc_nvm_model.sv
// nonvolatile memory loader stand-in answering start pulses
`timescale 1ns/1ps
module dmc_nvm_model (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // loader handshake
    input wire logic start,
    output logic done,
    output logic ok,
    // behaviour
    input wire logic [7:0] delay,
    input wire logic ok_cfg
);
    logic [7:0] cnt_r;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cnt_r <= 8'h00;
        end else if (start) begin
            cnt_r <= delay;
        end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end
    assign done = (cnt_r == 8'h01);
    // result undefined outside done, so show the opposite
    assign ok = done ? ok_cfg : !ok_cfg;
endmodule : dmc_nvm_model

// ===== dv/dmc_regs_properties.sv
// port-level checks for the dac control register bank
`timescale 1ns/1ps
module dmc_regs_props
    import dmc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pslverr,
    // block side
    input wire logic [EVT_W-1:0] link_event,
    input wire logic nvm_load_start,
    input wire logic [NUM_DACS-1:0] flush_enable,
    input wire logic pll_powerdown_first,
    input wire logic pll_powerdown_second,
    input wire logic irq
);
    default clocking cb @(posedge clock);
    endclocking
    logic wr;
    assign wr = psel && penable && pwrite;

    AST_START_PULSE: assert property (disable iff (!nrst)
        nvm_load_start |=> !nvm_load_start) else $error("start pulse too long");
    AST_START_CAUSE: assert property (disable iff (!nrst)
        $rose(nvm_load_start) |-> $past(wr && paddr == {IDX_BOOT, 2'b00} && pwdata[0]))
        else $error("start pulse without start write");
    AST_FLUSH_RST: assert property (
        !nrst |=> flush_enable == {NUM_DACS{1'b1}}) else $error("flush reset wrong");
    AST_PLL_RST: assert property (
        !nrst |=> pll_powerdown_second && !pll_powerdown_first) else $error("pll reset wrong");
    AST_IRQ_RST: assert property (
        !nrst |=> !irq) else $error("irq high after reset");
    AST_IRQ_CAUSE: assert property (disable iff (!nrst)
        $rose(irq) |-> $past(link_event != 9'h000 || wr, 2)) else $error("irq without cause");
    AST_RD_HI: assert property (disable iff (!nrst)
        psel && penable && !pwrite && paddr == {IDX_IRQ_EN_HI, 2'b00} |-> prdata[31:1] == 0)
        else $error("reserved mask bits read nonzero");
    AST_FLUSH_HOLD: assert property (disable iff (!nrst)
        $past(nrst) && $changed(flush_enable) |-> $past(wr && paddr == {IDX_FLUSH, 2'b00}))
        else $error("flush changed without write");
    COV_IRQ: cover property (disable iff (!nrst) $rose(irq));
    COV_BOOT: cover property (disable iff (!nrst) nvm_load_start);
    COV_ERR: cover property (disable iff (!nrst) pslverr);
endmodule : dmc_regs_props

bind dmc_regs dmc_regs_props u_props (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
    .link_event(link_event), .nvm_load_start(nvm_load_start), .flush_enable(flush_enable),
    .pll_powerdown_first(pll_powerdown_first), .pll_powerdown_second(pll_powerdown_second),
    .irq(irq)
);

// ===== dv/tb_top.sv
// self-checking bench for the dac control register bank
`timescale 1ns/1ps
module tb_top;
    import dmc_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [8:0] link_event = 9'h000;
    logic ok_cfg = 1'b1;
    logic [7:0] dly = 8'h0a;
    logic pready, pslverr, start, ld_done, ld_ok, irq;
    logic [31:0] prdata;
    logic [1:0] flush_enable;
    wire [7:0] pll_a;
    wire [7:0] pll_b;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    logic [8:0] m;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;

    always #50 clock = ~clock;

    dmc_regs u_dmc_regs (
        .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .link_event(link_event), .nvm_load_start(start),
        .nvm_load_done(ld_done), .nvm_load_ok(ld_ok), .flush_enable(flush_enable),
        .pll_powerdown_first(pll_a[0]), .pll_powerdown_second(pll_a[1]),
        .pll_powerdown_third(pll_a[2]), .pll_powerdown_fourth(pll_a[3]),
        .pll_powerdown_fifth(pll_a[6:4]), .pll_powerdown_sixth(pll_a[7]),
        .pll_powerdown_seventh(pll_b[0]), .pll_powerdown_eighth(pll_b[1]),
        .pll_powerdown_ninth(pll_b[2]), .pll_powerdown_tenth(pll_b[3]),
        .pll_powerdown_eleventh(pll_b[4]), .pll_spare(pll_b[7:5]), .irq(irq)
    );

    dmc_nvm_model u_dmc_nvm_model (
        .clock(clock), .nrst(nrst), .start(start), .done(ld_done), .ok(ld_ok),
        .delay(dly), .ok_cfg(ok_cfg)
    );

    task automatic final_report();
        if (fail_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    task automatic cmp(string what, logic [32:0] exp, logic [32:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    // one apb transfer; expected {pslverr, prdata} queued for the monitor
    task automatic xfer(logic we, logic [IDX_W-1:0] idx, logic [7:0] wd, logic [32:0] exp);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= we;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        exp_q.push_back(exp);
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(logic [IDX_W-1:0] idx, logic [7:0] d);
        xfer(1'b1, idx, d, 33'h0);
    endtask : wr

    task automatic rd(logic [IDX_W-1:0] idx, logic [7:0] d);
        xfer(1'b0, idx, 8'h00, {25'h0, d});
    endtask : rd

    always @(posedge clock) begin
        if (psel && penable && pready) begin
            e = exp_q.pop_front();
            if (pwrite) begin
                cmp("pslverr", {32'h0, e[32]}, {32'h0, pslverr});
            end else begin
                cmp("apb read", e, {pslverr, prdata});
            end
        end
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            final_report();
        end
    end

    initial begin
        void'($urandom(29));
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        rd(IDX_IRQ_EN_LO, 8'h00);
        rd(IDX_IRQ_EN_HI, 8'h00);
        rd(IDX_FLUSH, 8'h01);
        rd(IDX_BOOT, 8'h00);
        rd(IDX_PLL_A, 8'h02);
        rd(IDX_PLL_B, 8'h00);
        xfer(1'b0, 14'h0100, 8'h00, {1'b1, 32'h0});
        m = 9'($urandom());
        wr(IDX_IRQ_EN_LO, m[7:0]);
        wr(IDX_IRQ_EN_HI, {7'h7f, m[8]});
        rd(IDX_IRQ_EN_LO, m[7:0]);
        rd(IDX_IRQ_EN_HI, {7'h00, m[8]});
        for (int i = 0; i < EVT_W; i++) begin
            @(posedge clock);
            link_event <= 9'h001 << i;
            @(posedge clock);
            link_event <= 9'h000;
            repeat (2) @(posedge clock);
            cmp("irq", {32'h0, m[i]}, {32'h0, irq});
            if (i < 8) rd(IDX_IRQ_STAT_LO, 8'h01 << i);
            else rd(IDX_IRQ_STAT_HI, 8'h01);
            wr(IDX_IRQ_CLR_LO, 8'hff);
            wr(IDX_IRQ_CLR_HI, 8'h01);
            repeat (2) @(posedge clock);
            cmp("irq", 33'h0, {32'h0, irq});
        end
        wr(IDX_PAGE, 8'h01);
        wr(IDX_FLUSH, 8'h00);
        @(posedge clock);
        cmp("flush_enable", 33'h2, {31'h0, flush_enable});
        wr(IDX_PAGE, 8'h02);
        rd(IDX_FLUSH, 8'h01);
        wr(IDX_PAGE, 8'h03);
        rd(IDX_FLUSH, 8'h00);
        // slow successful load, then prompt failing load
        for (int k = 1; k >= 0; k--) begin
            ok_cfg <= k[0];
            dly <= k[0] ? 8'h0a : 8'h02;
            wr(IDX_BOOT, 8'h01);
            if (k == 1) rd(IDX_BOOT, 8'h01);
            repeat (12) @(posedge clock);
            rd(IDX_BOOT, {6'h00, k[0], 1'b0});
        end
        // bypass: every powerdown up, then bank a cleared while bank b stays up
        wr(IDX_PLL_A, 8'hff);
        wr(IDX_PLL_B, 8'h1f);
        @(posedge clock);
        cmp("pll a", 33'hff, {25'h0, pll_a});
        cmp("pll b", 33'h1f, {25'h0, pll_b});
        wr(IDX_PLL_A, 8'h00);
        rd(IDX_PLL_A, 8'h00);
        final_report();
    end
endmodule : tb_top

// ===== include/dmc_pkg.sv
// package of offsets, fields, reset values and states for the dac control register bank
package dmc_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int IDX_W = 14;
    localparam int REG_W = 8;
    localparam int EVT_W = 9;
    localparam int NUM_DACS = 2;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_PAGE = 14'h0008;
    localparam logic [IDX_W-1:0] IDX_IRQ_EN_LO = 14'h0597;
    localparam logic [IDX_W-1:0] IDX_IRQ_EN_HI = 14'h0598;
    localparam logic [IDX_W-1:0] IDX_FLUSH = 14'h0599;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT_LO = 14'h059a;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT_HI = 14'h059b;
    localparam logic [IDX_W-1:0] IDX_IRQ_CLR_LO = 14'h059c;
    localparam logic [IDX_W-1:0] IDX_IRQ_CLR_HI = 14'h059d;
    localparam logic [IDX_W-1:0] IDX_BOOT = 14'h0705;
    localparam logic [IDX_W-1:0] IDX_PLL_A = 14'h0790;
    localparam logic [IDX_W-1:0] IDX_PLL_B = 14'h0791;

    // reset values
    localparam logic [REG_W-1:0] RST_IRQ_EN_LO = 8'h00;
    localparam logic RST_IRQ_EN_HI = 1'h0;
    localparam logic RST_FLUSH = 1'h1;
    localparam logic [NUM_DACS-1:0] RST_PAGE = 2'h3;
    localparam logic [REG_W-1:0] RST_PLL_A = 8'h02;
    localparam logic [REG_W-1:0] RST_PLL_B = 8'h00;

    // field positions
    localparam int IRQ_HI_BIT = 0;
    localparam int FLUSH_BIT = 0;
    localparam int BOOT_START_BIT = 0;
    localparam int BOOT_DONE_BIT = 1;
    localparam int EVT_CGS = 8;
    localparam int EVT_FRAME_SYNC = 7;
    localparam int EVT_GOOD_CHKSUM = 6;
    localparam int EVT_ILANE_SYNC = 5;
    localparam int EVT_DESKEW = 4;
    localparam int EVT_DISPARITY = 3;
    localparam int EVT_NOT_IN_TABLE = 2;
    localparam int EVT_UNEXP_CTRL = 1;
    localparam int EVT_LANE_BUF = 0;

    // boot loader sequencer, gray along idle -> load -> finish
    typedef enum logic [1:0] {
        BOOT_IDLE = 2'h0,
        BOOT_LOAD = 2'h1,
        BOOT_FINISH = 2'h3
    } dmc_boot_e;

endpackage : dmc_pkg

// ===== rtl/dmc_event_latch.sv
// sticky event flags with set-over-clear priority
`timescale 1ns/1ps
module dmc_event_latch #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // events and clears
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    // flags
    output logic [W-1:0] flag
);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            flag <= '0;
        end else begin
            // a set in the clearing cycle wins
            flag <= (flag & ~clr) | set;
        end
    end

endmodule : dmc_event_latch

// ===== rtl/dmc_regs.sv
// dac control register bank: link interrupt mask, path flush, boot loader, pll powerdowns
`timescale 1ns/1ps
module dmc_regs
    import dmc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,

    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [DATA_W-1:0] prdata,
    output logic pslverr,

    // link event pulses
    input wire logic [EVT_W-1:0] link_event,

    // nonvolatile memory loader
    output logic nvm_load_start,
    input wire logic nvm_load_done,
    input wire logic nvm_load_ok,

    // per dac path flush enables
    output logic [NUM_DACS-1:0] flush_enable,

    // pll powerdown controls
    output logic pll_powerdown_first,
    output logic pll_powerdown_second,
    output logic pll_powerdown_third,
    output logic pll_powerdown_fourth,
    output logic [2:0] pll_powerdown_fifth,
    output logic pll_powerdown_sixth,
    output logic pll_powerdown_seventh,
    output logic pll_powerdown_eighth,
    output logic pll_powerdown_ninth,
    output logic pll_powerdown_tenth,
    output logic pll_powerdown_eleventh,
    output logic [2:0] pll_spare,

    // interrupt
    output logic irq
);

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic setup_phase;
    logic access_phase;
    logic [IDX_W-1:0] idx;
    logic aligned;
    logic hit;
    logic wr_en;
    logic [REG_W-1:0] wbyte;

    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    assign idx = paddr[ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign wbyte = pwdata[REG_W-1:0];

    always_comb begin
        hit = 1'b0;
        if (aligned) begin
            case (idx)
                IDX_PAGE,
                IDX_IRQ_EN_LO,
                IDX_IRQ_EN_HI,
                IDX_FLUSH,
                IDX_IRQ_STAT_LO,
                IDX_IRQ_STAT_HI,
                IDX_IRQ_CLR_LO,
                IDX_IRQ_CLR_HI,
                IDX_BOOT,
                IDX_PLL_A,
                IDX_PLL_B: hit = 1'b1;
                default: hit = 1'b0;
            endcase
        end
    end

    // writes land at the access edge; only byte lane 0 carries data
    assign wr_en = access_phase & pwrite & hit & pstrb[0];

    // ------------------------------------------------------------------
    // page select
    // ------------------------------------------------------------------
    logic [NUM_DACS-1:0] page_sel_r;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            page_sel_r <= RST_PAGE;
        end else if (wr_en && idx == IDX_PAGE) begin
            page_sel_r <= wbyte[NUM_DACS-1:0];
        end
    end

    // ------------------------------------------------------------------
    // link interrupt enable mask
    // ------------------------------------------------------------------
    logic [REG_W-1:0] irq_en_lo_r;
    logic irq_en_hi_r;
    logic [EVT_W-1:0] irq_mask;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            irq_en_lo_r <= RST_IRQ_EN_LO;
        end else if (wr_en && idx == IDX_IRQ_EN_LO) begin
            irq_en_lo_r <= wbyte;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            irq_en_hi_r <= RST_IRQ_EN_HI;
        end else if (wr_en && idx == IDX_IRQ_EN_HI) begin
            irq_en_hi_r <= wbyte[IRQ_HI_BIT];
        end
    end

    // mask bit n gates event n; bit 8 lives in the high register
    assign irq_mask = {irq_en_hi_r, irq_en_lo_r};

    // ------------------------------------------------------------------
    // event status and interrupt
    // ------------------------------------------------------------------
    logic [EVT_W-1:0] evt_clr;
    logic [EVT_W-1:0] evt_status;

    always_comb begin
        evt_clr = '0;
        if (wr_en && idx == IDX_IRQ_CLR_LO) begin
            evt_clr[REG_W-1:0] = wbyte;
        end
        if (wr_en && idx == IDX_IRQ_CLR_HI) begin
            evt_clr[EVT_CGS] = wbyte[IRQ_HI_BIT];
        end
    end

    // event order on link_event matches the mask layout
    dmc_event_latch #(
        .W(EVT_W)
    ) u_evt (
        .clock(clock),
        .nrst(nrst),
        .set(link_event),
        .clr(evt_clr),
        .flag(evt_status)
    );

    always_ff @(posedge clock) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evt_status & irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // per dac path flush enable
    // ------------------------------------------------------------------
    logic [NUM_DACS-1:0] flush_r;
    logic flush_rd;

    genvar g;
    generate
        for (g = 0; g < NUM_DACS; g = g + 1) begin : g_flush
            always_ff @(posedge clock) begin
                if (!nrst) begin
                    flush_r[g] <= RST_FLUSH;
                end else if (wr_en && idx == IDX_FLUSH && page_sel_r[g]) begin
                    flush_r[g] <= wbyte[FLUSH_BIT];
                end
            end
        end
    endgenerate

    // reads return the lowest selected page
    always_comb begin
        flush_rd = 1'b0;
        for (int i = NUM_DACS - 1; i >= 0; i--) begin
            if (page_sel_r[i]) begin
                flush_rd = flush_r[i];
            end
        end
    end

    assign flush_enable = flush_r;

    // ------------------------------------------------------------------
    // boot loader
    // ------------------------------------------------------------------
    dmc_boot_e boot_state_r;
    logic boot_start_r;
    logic boot_done_r;
    logic boot_kick;

    assign boot_kick = wr_en && idx == IDX_BOOT && wbyte[BOOT_START_BIT];

    always_ff @(posedge clock) begin
        if (!nrst) begin
            boot_state_r <= BOOT_IDLE;
        end else begin
            case (boot_state_r)
                BOOT_IDLE: begin
                    if (boot_kick) begin
                        boot_state_r <= BOOT_LOAD;
                    end
                end
                BOOT_LOAD: begin
                    if (nvm_load_done) begin
                        boot_state_r <= BOOT_FINISH;
                    end
                end
                BOOT_FINISH: begin
                    boot_state_r <= BOOT_IDLE;
                end
                default: begin
                    boot_state_r <= BOOT_IDLE;
                end
            endcase
        end
    end

    // start bit: set by software, cleared only by the loader ending
    always_ff @(posedge clock) begin
        if (!nrst) begin
            boot_start_r <= 1'b0;
        end else if (boot_state_r == BOOT_IDLE && boot_kick) begin
            boot_start_r <= 1'b1;
        end else if (boot_state_r == BOOT_LOAD && nvm_load_done) begin
            boot_start_r <= 1'b0;
        end
    end

    // done flag: cleared on a new start, set only on success
    always_ff @(posedge clock) begin
        if (!nrst) begin
            boot_done_r <= 1'b0;
        end else if (boot_state_r == BOOT_IDLE && boot_kick) begin
            boot_done_r <= 1'b0;
        end else if (boot_state_r == BOOT_LOAD && nvm_load_done) begin
            boot_done_r <= nvm_load_ok;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            nvm_load_start <= 1'b0;
        end else begin
            nvm_load_start <= (boot_state_r == BOOT_IDLE) && boot_kick;
        end
    end

    // ------------------------------------------------------------------
    // pll powerdown controls
    // ------------------------------------------------------------------
    logic [REG_W-1:0] pll_a_r;
    logic [REG_W-1:0] pll_b_r;

    // plain storage; software owns the bypass settings
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pll_a_r <= RST_PLL_A;
        end else if (wr_en && idx == IDX_PLL_A) begin
            pll_a_r <= wbyte;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pll_b_r <= RST_PLL_B;
        end else if (wr_en && idx == IDX_PLL_B) begin
            pll_b_r <= wbyte;
        end
    end

    assign pll_powerdown_first = pll_a_r[0];
    assign pll_powerdown_second = pll_a_r[1];
    assign pll_powerdown_third = pll_a_r[2];
    assign pll_powerdown_fourth = pll_a_r[3];
    assign pll_powerdown_fifth = pll_a_r[6:4];
    assign pll_powerdown_sixth = pll_a_r[7];
    assign pll_powerdown_seventh = pll_b_r[0];
    assign pll_powerdown_eighth = pll_b_r[1];
    assign pll_powerdown_ninth = pll_b_r[2];
    assign pll_powerdown_tenth = pll_b_r[3];
    assign pll_powerdown_eleventh = pll_b_r[4];
    assign pll_spare = pll_b_r[7:5];

    // ------------------------------------------------------------------
    // read mux, captured in the setup cycle
    // ------------------------------------------------------------------
    logic [REG_W-1:0] rd_byte;
    logic [DATA_W-1:0] prdata_r;
    logic err_r;

    always_comb begin
        rd_byte = '0;
        case (idx)
            IDX_PAGE: rd_byte = {{(REG_W - NUM_DACS){1'b0}}, page_sel_r};
            IDX_IRQ_EN_LO: rd_byte = irq_en_lo_r;
            IDX_IRQ_EN_HI: rd_byte = {7'h00, irq_en_hi_r};
            IDX_FLUSH: rd_byte = {7'h00, flush_rd};
            IDX_IRQ_STAT_LO: rd_byte = evt_status[REG_W-1:0];
            IDX_IRQ_STAT_HI: rd_byte = {7'h00, evt_status[EVT_CGS]};
            IDX_BOOT: rd_byte = {6'h00, boot_done_r, boot_start_r};
            IDX_PLL_A: rd_byte = pll_a_r;
            IDX_PLL_B: rd_byte = pll_b_r;
            default: rd_byte = '0;
        endcase
        if (!aligned) begin
            rd_byte = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            prdata_r <= '0;
        end else if (setup_phase) begin
            prdata_r <= pwrite ? '0 : {24'h000000, rd_byte};
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            err_r <= 1'b0;
        end else if (setup_phase) begin
            err_r <= ~hit;
        end
    end

    // zero wait state: every access phase completes at once
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = access_phase & err_r;

endmodule : dmc_regs
